/* File: shared/mcec_consts.svh */
/*
  Constants for the machine-check error capture block: register byte offsets,
  status word field positions, event codes, retry limit and halt codes.
  Assumes a single processor clock; included by bare name.
*/
`ifndef MCEC_CONSTS_SVH
`define MCEC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MCEC_OFF_STATUS   8'h00
`define MCEC_OFF_PCFAIL   8'h04
`define MCEC_OFF_UPCFAIL  8'h08
`define MCEC_OFF_CURPC    8'h0C
`define MCEC_OFF_CURPSL   8'h10
`define MCEC_OFF_BYTECNT  8'h14
`define MCEC_OFF_SUMMARY  8'h18
`define MCEC_OFF_PCTLCSR  8'h1C
`define MCEC_OFF_CTRL     8'h20
`define MCEC_OFF_HALT     8'h24

// ****************************************
// Status word fields
// ****************************************
`define MCEC_BIT_LOCK     0
`define MCEC_BIT_PCERR    1
`define MCEC_BIT_WRMEM    21
`define MCEC_BIT_BUSERR   22
`define MCEC_EVT_LSB      16
`define MCEC_EVT_MSB      20
`define MCEC_PSL_FPD      27

// ****************************************
// Event codes
// ****************************************
`define MCEC_EV_NONE        5'h00
`define MCEC_EV_MDONE       5'h01
`define MCEC_EV_SRDACK      5'h02
`define MCEC_EV_BUSTO       5'h03
`define MCEC_EV_STPASS      5'h04
`define MCEC_EV_RETRYCNF    5'h05
`define MCEC_EV_IREGWR      5'h06
`define MCEC_EV_ADVRETRY    5'h07
`define MCEC_EV_EXTV4       5'h0C
`define MCEC_EV_SSTALL      5'h10
`define MCEC_EV_BUSBUSY     5'h13
`define MCEC_EV_NEACK4      5'h14
`define MCEC_EV_RDSUB       5'h18
`define MCEC_EV_MCMDBAD     5'h19
`define MCEC_EV_MCMDNAK     5'h1A
`define MCEC_EV_PARADV      5'h1B
`define MCEC_EV_MDATABAD    5'h1C
`define MCEC_EV_RETRYTO     5'h1D
`define MCEC_EV_MPARITY     5'h1E
`define MCEC_EV_XMITCHK     5'h1F

// ****************************************
// Counts and codes
// ****************************************
`define MCEC_RETRY_LIMIT  13'd4096
`define MCEC_BYTE_COUNT   32'h0000_0020
`define MCEC_HALT_DOUBLE  8'h05
`define MCEC_HALT_CONSOLE 8'h4C
`define MCEC_HALT_NONE    8'h00

`endif

/* File: shared/mcec_pkg.sv */
/*
  Types for the machine-check error capture block.
  Assumes mcec_consts.svh for numeric constants.
*/
package mcec_pkg;

  typedef struct packed {
    logic        valid;
    logic [4:0]  code;
    logic        wrMem;
  } mcec_busev_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] microPc;
    logic [31:0] curPc;
    logic [31:0] curPsl;
  } mcec_cpustate_t;

  typedef enum logic [1:0] {
    MCEC_RUN,
    MCEC_FRAME,
    MCEC_CONSOLE
  } mcec_state_t;

endpackage

/* File: hdl/mcec_capture.sv */
/*
  Machine-check error capture: classifies bus events from the port
  controller, locks the status word on bus errors, saves the stack frame
  values, detects double errors and diverts errors to the console while in
  power-up or console mode. Registers sit on an AHB-Lite slave.
  Assumes one clock, synchronous active-low reset, one AHB master.
*/
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "mcec_consts.svh"

// Notes on behaviour
// - Lock bit set means status bits 22:1 hold valid captured information.
// - Failing address is valid only while write-memory bit 21 is clear.
// - Codes 0,1,2,4,6 are non-error events passed through unchanged.
// - Code 3 bus timeout sets bus-error bit 22.
// - Codes 5,7,8,9,A,B are retry, no-ack, error vector and arbitration events.
// - Codes C to F report external vector selection at levels 4 to 7.
// - Codes 10 to 13 report slave stall, parity, bad confirm, bus busy.
// - Codes 14 to 17 report non-error vector acks at levels 4 to 7.
// - Code 18 read data substitute sets bus-error bit 22.
// - Codes 19 and 1C illegal master confirmations set bus-error bit 22.
// - Code 1A master command no-ack sets bus-error bit 22.
// - Code 1B gives advance notice of bad parity, no lock.
// - After 4096 consecutive retries capture code 1D and set bit 22.
// - Bad parity while master captures code 1E and sets bit 22.
// - Transmit check mismatch as sole driver captures 1F, sets bit 22.
// - Frame entry 1C holds the program counter at error detection.
// - Frame entry 20 holds next micro-address at error detection.
// - Frame entry 24 holds start address of the failing instruction.
// - Frame entry 28 holds current status longword with bit 27 first-part-done.
// - Second error while in-progress flag set halts with code 05, run off.
// - Double-error halt pushes no frame; holding registers stay readable.
// - Power-up or console errors set error-state, go to console code 4C.
// - Bit 22 freezes bit 21 and code until software clears bit 22.
// - First frame entry holds byte count 20 hex.
module mcec_capture (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire mcec_pkg::mcec_busev_t busEvent,
  input  wire logic                  retryCnf,
  input  wire logic                  masterDone,
  input  wire logic                  masterParityBad,
  input  wire logic                  soleDriver,
  input  wire logic [31:0]           driveData,
  input  wire logic [31:0]           sampleData,
  input  wire mcec_pkg::mcec_cpustate_t cpuState,
  input  wire logic                  consoleMode,
  output logic                       machineCheck,
  output logic                       runLight,
  output logic                       consoleHalt,
  output logic      [7:0]            haltCode
);

  // ****************************************
  // Bus event classification
  // ****************************************
  function automatic logic isBusError(input logic [4:0] code);
    case (code)
      `MCEC_EV_BUSTO,
      `MCEC_EV_RDSUB,
      `MCEC_EV_MCMDBAD,
      `MCEC_EV_MDATABAD,
      `MCEC_EV_MCMDNAK,
      `MCEC_EV_RETRYTO,
      `MCEC_EV_MPARITY,
      `MCEC_EV_XMITCHK: isBusError = 1'b1;
      default:          isBusError = 1'b0;
    endcase
  endfunction

  logic [12:0]           retryCount;
  logic                  retryExpired;
  logic                  xmitMismatch;
  logic [4:0]            next_code;
  logic                  next_valid;

  assign retryExpired = retryCnf && (retryCount == `MCEC_RETRY_LIMIT - 13'd1);
  assign xmitMismatch = soleDriver && (driveData != sampleData);

  // Locally detected errors outrank whatever the port controller reports
  always_comb begin
    next_valid = 1'b1;
    if (retryExpired) begin
      next_code = `MCEC_EV_RETRYTO;
    end else if (xmitMismatch) begin
      next_code = `MCEC_EV_XMITCHK;
    end else if (masterParityBad) begin
      next_code = `MCEC_EV_MPARITY;
    end else begin
      next_code  = busEvent.code;
      next_valid = busEvent.valid;
    end
  end

  // Counts consecutive retries; any completion restarts the count
  always_ff @(posedge clk_sys) begin
    if (!rst_n || masterDone || retryExpired) begin
      retryCount <= 13'h0000;
    end else if (retryCnf) begin
      retryCount <= retryCount + 13'd1;
    end
  end

  // ****************************************
  // Status word capture
  // ****************************************
  logic       busErr;
  logic       wrMem;
  logic [4:0] evCode;
  logic       newBusErr;
  logic       clrBusErr;

  assign newBusErr = next_valid && isBusError(next_code) && !busErr;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      evCode <= `MCEC_EV_NONE;
      wrMem  <= 1'b0;
      busErr <= 1'b0;
    end else if (!busErr || clrBusErr) begin
      if (next_valid) begin
        evCode <= next_code;
        wrMem  <= busEvent.wrMem;
      end
      // Set wins over a clear in the same cycle
      busErr <= next_valid && isBusError(next_code);
    end
  end

  // ****************************************
  // Error sequencing
  // ****************************************
  mcec_pkg::mcec_state_t state;
  logic                  inProgress;
  logic                  errorState;
  logic                  clrProgress;
  logic [31:0]           savePc;
  logic [31:0]           saveUpc;
  logic [31:0]           saveCurPc;
  logic [31:0]           saveCurPsl;
  logic                  frameValid;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state      <= mcec_pkg::MCEC_RUN;
      inProgress <= 1'b0;
      errorState <= 1'b0;
      haltCode   <= `MCEC_HALT_NONE;
      frameValid <= 1'b0;
    end else begin
      case (state)
        mcec_pkg::MCEC_RUN: begin
          if (newBusErr) begin
            if (consoleMode) begin
              errorState <= 1'b1;
              haltCode   <= `MCEC_HALT_CONSOLE;
              state      <= mcec_pkg::MCEC_CONSOLE;
            end else if (inProgress && !clrProgress) begin
              haltCode   <= `MCEC_HALT_DOUBLE;
              frameValid <= 1'b0;
              state      <= mcec_pkg::MCEC_CONSOLE;
            end else begin
              inProgress <= 1'b1;
              frameValid <= 1'b1;
              state      <= mcec_pkg::MCEC_FRAME;
            end
          end else if (clrProgress) begin
            inProgress <= 1'b0;
          end
        end
        mcec_pkg::MCEC_FRAME: begin
          state <= mcec_pkg::MCEC_RUN;
        end
        mcec_pkg::MCEC_CONSOLE: begin
          // Left only by reset; console owns the machine now
          state <= mcec_pkg::MCEC_CONSOLE;
        end
        default: state <= mcec_pkg::MCEC_RUN;
      endcase
    end
  end

  // Holding registers keep the snapshot even after a double-error halt
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      savePc     <= 32'h0000_0000;
      saveUpc    <= 32'h0000_0000;
      saveCurPc  <= 32'h0000_0000;
      saveCurPsl <= 32'h0000_0000;
    end else if (newBusErr && state == mcec_pkg::MCEC_RUN && (!inProgress || clrProgress)) begin
      savePc     <= cpuState.pc;
      saveUpc    <= cpuState.microPc;
      saveCurPc  <= cpuState.curPc;
      saveCurPsl <= cpuState.curPsl;
    end
  end

  assign machineCheck = (state == mcec_pkg::MCEC_FRAME);
  assign consoleHalt  = (state == mcec_pkg::MCEC_CONSOLE);
  assign runLight     = (state != mcec_pkg::MCEC_CONSOLE);

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic       dPhase;
  logic       dWrite;
  logic [7:0] dAddr;
  logic [31:0] statusWord;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dPhase <= 1'b0;
      dWrite <= 1'b0;
      dAddr  <= 8'h00;
    end else if (hready) begin
      dPhase <= hsel && htrans[1];
      dWrite <= hwrite;
      dAddr  <= haddr;
    end
  end

  assign clrProgress = dPhase && dWrite && dAddr == `MCEC_OFF_SUMMARY;
  assign clrBusErr   = dPhase && dWrite && dAddr == `MCEC_OFF_PCTLCSR && hwdata[`MCEC_BIT_BUSERR];

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`MCEC_BIT_BUSERR]            = busErr;
    statusWord[`MCEC_BIT_WRMEM]             = wrMem;
    statusWord[`MCEC_EVT_MSB:`MCEC_EVT_LSB] = evCode;
    statusWord[`MCEC_BIT_PCERR]             = busErr;
    statusWord[`MCEC_BIT_LOCK]              = busErr && !wrMem;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr)
        `MCEC_OFF_STATUS:  hrdata <= statusWord;
        `MCEC_OFF_PCTLCSR: hrdata <= statusWord;
        `MCEC_OFF_PCFAIL:  hrdata <= savePc;
        `MCEC_OFF_UPCFAIL: hrdata <= saveUpc;
        `MCEC_OFF_CURPC:   hrdata <= saveCurPc;
        `MCEC_OFF_CURPSL:  hrdata <= saveCurPsl;
        `MCEC_OFF_BYTECNT: hrdata <= `MCEC_BYTE_COUNT;
        `MCEC_OFF_SUMMARY: hrdata <= {31'h0000_0000, inProgress};
        `MCEC_OFF_CTRL:    hrdata <= {30'h0000_0000, errorState, frameValid};
        `MCEC_OFF_HALT:    hrdata <= {24'h00_0000, haltCode};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // Assertions
  // ****************************************
  property p_busErrSets;
    @(posedge clk_sys) disable iff (!rst_n)
      (!busErr && next_valid && isBusError(next_code)) |=> busErr;
  endproperty
  a_busErrSets: assert property (p_busErrSets) else $error("bus error flag not set");

  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
      (busErr && !clrBusErr) |=> ($stable(evCode) && $stable(wrMem) && busErr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("locked fields changed");

  property p_nonErr;
    @(posedge clk_sys) disable iff (!rst_n)
      (!busErr && next_valid && next_code == `MCEC_EV_PARADV) |=> !busErr && evCode == `MCEC_EV_PARADV;
  endproperty
  a_nonErr: assert property (p_nonErr) else $error("advance parity locked");

  property p_retryTo;
    @(posedge clk_sys) disable iff (!rst_n)
      (retryExpired && !busErr) |=> busErr && evCode == `MCEC_EV_RETRYTO;
  endproperty
  a_retryTo: assert property (p_retryTo) else $error("retry timeout missed");

  property p_xmit;
    @(posedge clk_sys) disable iff (!rst_n)
      (xmitMismatch && !retryExpired && !busErr) |=> evCode == `MCEC_EV_XMITCHK;
  endproperty
  a_xmit: assert property (p_xmit) else $error("transmit check missed");

  property p_double;
    @(posedge clk_sys) disable iff (!rst_n)
      (state == mcec_pkg::MCEC_RUN && newBusErr && inProgress && !clrProgress && !consoleMode)
        |=> consoleHalt && !runLight && haltCode == `MCEC_HALT_DOUBLE && !machineCheck;
  endproperty
  a_double: assert property (p_double) else $error("double error not halted");

  property p_console;
    @(posedge clk_sys) disable iff (!rst_n)
      (state == mcec_pkg::MCEC_RUN && newBusErr && consoleMode)
        |=> errorState && haltCode == `MCEC_HALT_CONSOLE && !machineCheck;
  endproperty
  a_console: assert property (p_console) else $error("console error not diverted");

  property p_savePc;
    @(posedge clk_sys) disable iff (!rst_n)
      (state == mcec_pkg::MCEC_RUN && newBusErr && !inProgress)
        |=> savePc == $past(cpuState.pc) && saveCurPsl == $past(cpuState.curPsl);
  endproperty
  a_savePc: assert property (p_savePc) else $error("frame values not saved");

  property p_lockValid;
    @(posedge clk_sys) disable iff (!rst_n)
      statusWord[`MCEC_BIT_LOCK] |-> busErr && statusWord[`MCEC_BIT_PCERR] && !wrMem;
  endproperty
  a_lockValid: assert property (p_lockValid) else $error("lock bit without valid capture");

  property p_wrMemTrack;
    @(posedge clk_sys) disable iff (!rst_n)
      ((!busErr || clrBusErr) && next_valid) |=> wrMem == $past(busEvent.wrMem);
  endproperty
  a_wrMemTrack: assert property (p_wrMemTrack) else $error("write-memory flag not tracked");

  property p_codeTrack;
    @(posedge clk_sys) disable iff (!rst_n)
      ((!busErr || clrBusErr) && next_valid) |=> evCode == $past(next_code);
  endproperty
  a_codeTrack: assert property (p_codeTrack) else $error("event code not tracked");

  property p_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      (!busErr && next_valid && !isBusError(next_code)) |=> !busErr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("non-error event locked");

  property p_portErr;
    @(posedge clk_sys) disable iff (!rst_n)
      (!busErr && next_valid && (next_code == `MCEC_EV_RDSUB || next_code == `MCEC_EV_MCMDBAD ||
        next_code == `MCEC_EV_MCMDNAK || next_code == `MCEC_EV_MDATABAD)) |=> busErr;
  endproperty
  a_portErr: assert property (p_portErr) else $error("port error not locked");

  property p_parity;
    @(posedge clk_sys) disable iff (!rst_n)
      (masterParityBad && !retryExpired && !xmitMismatch && !busErr) |=> busErr && evCode == `MCEC_EV_MPARITY;
  endproperty
  a_parity: assert property (p_parity) else $error("master parity missed");

  property p_noFrame;
    @(posedge clk_sys) disable iff (!rst_n)
      (haltCode == `MCEC_HALT_DOUBLE) |-> !frameValid && !machineCheck;
  endproperty
  a_noFrame: assert property (p_noFrame) else $error("frame pushed on double error");

  property p_clrProgress;
    @(posedge clk_sys) disable iff (!rst_n)
      (state == mcec_pkg::MCEC_RUN && clrProgress && !newBusErr) |=> !inProgress;
  endproperty
  a_clrProgress: assert property (p_clrProgress) else $error("in-progress flag not cleared");

  property p_resetClear;
    @(posedge clk_sys)
      !rst_n |=> !inProgress && !errorState && evCode == `MCEC_EV_NONE && !consoleHalt;
  endproperty
  a_resetClear: assert property (p_resetClear) else $error("reset left error state");

endmodule

/* File: test/mcec_port_model.sv */
/*
  Behavioural port controller for the machine-check capture bench: bus events,
  retry confirmations, master parity and transmit-check traffic on demand.
  Assumes the bench calls its tasks right after a rising clk_sys edge.
*/
`timescale 1ns/1ps
module mcec_port_model (
  input  wire logic             clk_sys,
  output mcec_pkg::mcec_busev_t busEvent,
  output logic                  retryCnf,
  output logic                  masterDone,
  output logic                  masterParityBad,
  output logic                  soleDriver,
  output logic [31:0]           driveData,
  output logic [31:0]           sampleData
);
  initial begin
    busEvent = '0;
    retryCnf = 1'b0;
    masterDone = 1'b0;
    masterParityBad = 1'b0;
    soleDriver = 1'b0;
    driveData = 32'h0000_0000;
    sampleData = 32'hFFFF_FFFF;
  end

  // ****************************************
  // Event traffic
  // ****************************************
  // Invalid cycles carry inverted fields so a stale code is never mistaken
  task automatic send_event(input logic [4:0] code, input logic wr);
    @(posedge clk_sys);
    busEvent <= '{valid: 1'b1, code: code, wrMem: wr};
    @(posedge clk_sys);
    busEvent <= '{valid: 1'b0, code: ~code, wrMem: ~wr};
  endtask

  task automatic retries(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      retryCnf <= 1'b1;
      @(posedge clk_sys);
      retryCnf <= 1'b0;
    end
  endtask

  task automatic done();
    @(posedge clk_sys);
    masterDone <= 1'b1;
    @(posedge clk_sys);
    masterDone <= 1'b0;
  endtask

  task automatic parity();
    @(posedge clk_sys);
    masterParityBad <= 1'b1;
    @(posedge clk_sys);
    masterParityBad <= 1'b0;
  endtask

  task automatic xmit(input logic [31:0] flip);
    @(posedge clk_sys);
    soleDriver <= 1'b1;
    driveData <= 32'hA5C3_0F96;
    sampleData <= 32'hA5C3_0F96 ^ flip;
    @(posedge clk_sys);
    soleDriver <= 1'b0;
    sampleData <= 32'h5A3C_F069;
  endtask
endmodule

/* File: test/tb_machine_check_error_capture.sv */
/*
  Self-checking bench for mcec_capture: AHB-Lite register tasks, event
  tables, retry limit, double error and console diversion.
  Assumes mcec_consts.svh and the port controller model.
*/
`timescale 1ns/1ps
`include "mcec_consts.svh"
module tb_machine_check_error_capture;
  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   hsel = 1'b0;
  logic [7:0]             haddr = 8'h00;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic [2:0]             hsize = 3'h0;
  logic [31:0]            hwdata = 32'h0000_0000;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  mcec_pkg::mcec_busev_t  busEvent;
  logic                   retryCnf, masterDone, masterParityBad, soleDriver;
  logic [31:0]            driveData, sampleData;
  mcec_pkg::mcec_cpustate_t cpuState = '0;
  logic                   consoleMode = 1'b0;
  logic                   machineCheck, runLight, consoleHalt;
  logic [7:0]             haltCode;
  int                     n_errors = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  int                     mcCount = 0;
  logic [4:0]             quietCodes [18] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h06, 5'h05, 5'h07, 5'h08, 5'h09,
                                              5'h0A, 5'h0B, 5'h0C, 5'h0F, 5'h10, 5'h13, 5'h14, 5'h17, 5'h1B};
  logic [4:0]             errCodes [5] = '{5'h03, 5'h18, 5'h19, 5'h1A, 5'h1C};

  always #2.5 clk_sys = ~clk_sys;

  mcec_capture i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .busEvent(busEvent), .retryCnf(retryCnf),
    .masterDone(masterDone), .masterParityBad(masterParityBad), .soleDriver(soleDriver),
    .driveData(driveData), .sampleData(sampleData), .cpuState(cpuState), .consoleMode(consoleMode),
    .machineCheck(machineCheck), .runLight(runLight), .consoleHalt(consoleHalt), .haltCode(haltCode));

  mcec_port_model i_port (.clk_sys(clk_sys), .busEvent(busEvent), .retryCnf(retryCnf),
    .masterDone(masterDone), .masterParityBad(masterParityBad), .soleDriver(soleDriver),
    .driveData(driveData), .sampleData(sampleData));

  // ****************************************
  // Reporting
  // ****************************************
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Hang guard: the retry test alone needs about 16k cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      close_out();
    end
  end

  always @(posedge clk_sys) begin
    if (machineCheck === 1'b1) begin
      mcCount <= mcCount + 1;
    end
  end

  // ****************************************
  // Bus access
  // ****************************************
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    chk(q & m, exp);
  endtask

  function automatic logic [31:0] stw(input logic [4:0] c, input logic w, input logic e);
    stw = {9'h000, e, w, c, 14'h0000, e, e & ~w};
  endfunction

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    consoleMode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task automatic release_error();
    wr(`MCEC_OFF_PCTLCSR, 32'h0040_0000);
    wr(`MCEC_OFF_SUMMARY, 32'h0000_00A5);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    do_reset();
    rc(`MCEC_OFF_STATUS, 32'h0000_0000);
    rc(`MCEC_OFF_BYTECNT, `MCEC_BYTE_COUNT);
    rc(8'h40, 32'h0000_0000);
    wr(8'h44, 32'hFFFF_FFFF);
    chk({29'h0, hresp, hreadyout, runLight}, 32'h0000_0003);
    $display("Test reset done");

    foreach (quietCodes[i]) begin
      i_port.send_event(quietCodes[i], 1'b0);
      settle();
      rc(`MCEC_OFF_STATUS, stw(quietCodes[i], 1'b0, 1'b0));
    end
    chk(mcCount, 0);
    $display("Test quiet codes done");

    foreach (errCodes[i]) begin
      cpuState <= '{pc: 32'h1000_0000 + i, microPc: 32'h0000_0200 + i, curPc: 32'h1000_0100 + i,
                    curPsl: 32'h0800_001F};
      i_port.send_event(errCodes[i], i[0]);
      settle();
      cpuState <= '1;
      rc(`MCEC_OFF_STATUS, stw(errCodes[i], i[0], 1'b1));
      rc(`MCEC_OFF_PCFAIL, 32'h1000_0000 + i);
      rc(`MCEC_OFF_UPCFAIL, 32'h0000_0200 + i);
      rc(`MCEC_OFF_CURPC, 32'h1000_0100 + i);
      rc(`MCEC_OFF_CURPSL, 32'h0800_001F);
      rc(`MCEC_OFF_CTRL, 32'h0000_0001, 32'h0000_0003);
      i_port.send_event(5'h01, ~i[0]);
      settle();
      rc(`MCEC_OFF_STATUS, stw(errCodes[i], i[0], 1'b1));
      chk(mcCount, i + 1);
      release_error();
      rc(`MCEC_OFF_SUMMARY, 32'h0000_0000, 32'h0000_0001);
    end
    $display("Test error codes done");

    i_port.xmit(32'h0000_0000);
    settle();
    rc(`MCEC_OFF_STATUS, 32'h0000_0000, 32'h0040_0000);
    i_port.xmit(32'h0001_0000);
    settle();
    rc(`MCEC_OFF_STATUS, stw(`MCEC_EV_XMITCHK, 1'b0, 1'b1), 32'h007F_0003);
    release_error();
    i_port.parity();
    settle();
    rc(`MCEC_OFF_STATUS, stw(`MCEC_EV_MPARITY, 1'b0, 1'b1), 32'h007F_0003);
    release_error();
    $display("Test parity and transmit done");

    i_port.retries(4095);
    i_port.done();
    i_port.retries(4095);
    settle();
    rc(`MCEC_OFF_STATUS, 32'h0000_0000, 32'h0040_0000);
    i_port.retries(1);
    settle();
    rc(`MCEC_OFF_STATUS, stw(`MCEC_EV_RETRYTO, 1'b0, 1'b1), 32'h007F_0003);
    wr(`MCEC_OFF_PCTLCSR, 32'h0040_0000);
    $display("Test retry limit done");

    // Retry timeout left the in-progress flag set, so this error is the second one
    cpuState <= '0;
    i_port.send_event(`MCEC_EV_BUSTO, 1'b0);
    settle();
    chk({consoleHalt, runLight, haltCode}, {2'b10, `MCEC_HALT_DOUBLE});
    chk(mcCount, 8);
    rc(`MCEC_OFF_PCFAIL, 32'hFFFF_FFFF);
    rc(`MCEC_OFF_CTRL, 32'h0000_0000, 32'h0000_0003);
    rc(`MCEC_OFF_HALT, 32'h0000_0005);
    rc(`MCEC_OFF_STATUS, stw(`MCEC_EV_BUSTO, 1'b0, 1'b1), 32'h007F_0003);
    do_reset();
    chk({consoleHalt, runLight, haltCode}, {2'b01, `MCEC_HALT_NONE});
    rc(`MCEC_OFF_SUMMARY, 32'h0000_0000, 32'h0000_0001);
    $display("Test double error done");

    consoleMode <= 1'b1;
    i_port.send_event(`MCEC_EV_MCMDBAD, 1'b0);
    settle();
    chk({consoleHalt, haltCode}, {1'b1, `MCEC_HALT_CONSOLE});
    chk(mcCount, 8);
    rc(`MCEC_OFF_CTRL, 32'h0000_0002, 32'h0000_0002);
    do_reset();
    rc(`MCEC_OFF_CTRL, 32'h0000_0000, 32'h0000_0002);
    $display("Test console diversion done");
    close_out();
  end
endmodule
